// [inc/fsps_pkg.sv]
/*
  Package for the flash self-program sequencer: register offsets, control
  bit positions, command patterns, lock-read pointer values and timing.
  Assumes a 10 MHz system clock and an APB register bus with 32-bit data.
*/
package fsps_pkg;
  localparam logic [7:0] OFF_CTRL   = 8'h00; // control/status
  localparam logic [7:0] OFF_CMD    = 8'h04; // store/load strobe
  localparam logic [7:0] OFF_PTR    = 8'h08; // index pointer
  localparam logic [7:0] OFF_DATA   = 8'h0C; // data register pair
  localparam logic [7:0] OFF_RDATA  = 8'h10; // load result
  localparam logic [7:0] OFF_STAT   = 8'h14; // loader lock bits
  localparam logic [7:0] OFF_EEPROM = 8'h18; // eeprom busy input mirror

  localparam int BIT_STORE_EN = 0;
  localparam int BIT_ERASE    = 1;
  localparam int BIT_WRITE    = 2;
  localparam int BIT_LOCKSET  = 3;
  localparam int BIT_REENABLE = 4;
  localparam int BIT_BUSY     = 6;
  localparam int BIT_IRQ_EN   = 7;

  localparam logic [4:0] CMD_LOAD  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK  = 5'h09;
  localparam logic [4:0] CMD_REEN  = 5'h11;

  localparam logic [15:0] PTR_FUSE_LO = 16'h0000;
  localparam logic [15:0] PTR_LOCK    = 16'h0001;
  localparam logic [15:0] PTR_FUSE_HI = 16'h0003;

  localparam int STORE_WINDOW = 4;
  localparam int LOAD_WINDOW  = 3;

  localparam int CLK_HZ       = 10000000;
  localparam int PROG_TIME_US = 3700; // least programming time
  localparam int PROG_CYCLES  = (PROG_TIME_US * (CLK_HZ / 1000000));

  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM  = 3'b010,
    ST_PROG = 3'b100
  } fsps_state_t;
endpackage

// [core/fsps_sequencer.sv]
/*
  Flash self-program sequencer: control register, temporary page buffer,
  page erase/write and lock-bit programming timed by a cycle counter,
  lock and fuse reads, region blocking and the ready request.
  Assumes an APB master at 10 MHz; the core issues stores and loads by
  writing the strobe register (bit 0 store, bit 1 load).
*/
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ns
module fsps_sequencer #(
  parameter int PAGE_BITS  = 7,
  parameter int WORD_BITS  = 6,
  parameter int PROG_COUNT = fsps_pkg::PROG_CYCLES,
  parameter logic [6:0] NO_READ_WHILE_WRITE_REGION_FIRST_PAGE = 7'h70
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        eeprom_write_busy_bit,
  input  wire logic [7:0]  low_fuse_byte,
  input  wire logic [7:0]  high_fuse_byte,
  input  wire logic [1:0]  memory_lock_bits,
  output logic             ready_irq,
  output logic             region_read_blocked,
  output logic             cpu_halt,
  output logic             flash_prog_busy,
  output logic [6:0]       flash_page_addr,
  output logic [1:0]       flash_prog_op,
  output logic [3:0]       loader_lock_bits
);
  import fsps_pkg::*;

  localparam int NWORDS = 1 << WORD_BITS;

  typedef struct packed {
    fsps_state_t           st;
    logic [7:0]            ctrl;
    logic [2:0]            win;
    logic [22:0]           cnt;
    logic [PAGE_BITS-1:0]  page;
    logic [1:0]            op;
    logic                  busy_rww;
    logic                  halt;
    logic [15:0]           ptr;
    logic [15:0]           data;
    logic [7:0]            rdata;
    logic [3:0]            locks;
    logic [NWORDS-1:0]     wvalid;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  irq;
  } fsps_regs_t;

  fsps_regs_t q, d;
  logic [15:0] buf_mem [NWORDS];

  logic wr_acc, rd_acc, store_now, load_now, buf_wr, pend_clr;
  logic [WORD_BITS-1:0] buf_idx;
  logic [4:0] cmd;

  always_comb begin
    wr_acc    = psel && penable && pwrite && !q.pready;
    rd_acc    = psel && penable && !pwrite && !q.pready;
    store_now = wr_acc && paddr == OFF_CMD && pwdata[0];
    load_now  = wr_acc && paddr == OFF_CMD && pwdata[1];
    cmd       = q.ctrl[4:0];
    buf_idx   = q.ptr[WORD_BITS:1];
    buf_wr    = 1'b0;
    pend_clr  = 1'b0;
    d         = q;
    d.pready  = psel && penable && !q.pready;
    d.pslverr = 1'b0;

    case (q.st)
      ST_IDLE: begin
        if (wr_acc && paddr == OFF_CTRL) begin
          d.ctrl[BIT_IRQ_EN] = pwdata[BIT_IRQ_EN];
          if (!eeprom_write_busy_bit &&
              (pwdata[4:0] == CMD_LOAD || pwdata[4:0] == CMD_ERASE ||
               pwdata[4:0] == CMD_WRITE || pwdata[4:0] == CMD_LOCK ||
               pwdata[4:0] == CMD_REEN)) begin
            d.ctrl[4:0] = pwdata[4:0];
            d.win       = 3'h0;
            d.st        = ST_ARM;
          end
        end
      end
      ST_ARM: begin
        d.win = q.win + 3'h1;
        if (store_now) begin
          d.ctrl[4:1] = 4'h0;
          d.ctrl[BIT_STORE_EN] = 1'b0;
          d.st = ST_IDLE;
          if (cmd == CMD_LOAD) begin
            buf_wr = !q.wvalid[buf_idx];
            d.wvalid[buf_idx] = 1'b1;
            d.busy_rww = 1'b0;
          end else if (cmd == CMD_REEN) begin
            pend_clr   = 1'b1;
            d.busy_rww = 1'b0;
          end else begin
            d.page = q.ptr[PAGE_BITS+6:7];
            d.cnt  = 23'(PROG_COUNT);
            d.ctrl[BIT_STORE_EN] = 1'b1;
            d.st   = ST_PROG;
            if (cmd == CMD_ERASE || cmd == CMD_WRITE) begin
              d.op = (cmd == CMD_ERASE) ? 2'h1 : 2'h2;
              d.halt = q.ptr[PAGE_BITS+6:7] >= NO_READ_WHILE_WRITE_REGION_FIRST_PAGE;
              // the main region is blocked for any erase or write
              d.busy_rww = 1'b1;
            end else begin
              d.op = 2'h3;
              d.locks = q.locks & q.data[5:2];
            end
          end
        end else if (load_now && cmd == CMD_LOCK &&
                     q.win < 3'(LOAD_WINDOW)) begin
          if (q.ptr == PTR_LOCK)
            d.rdata = {2'b11, q.locks, memory_lock_bits};
          else if (q.ptr == PTR_FUSE_HI)
            d.rdata = high_fuse_byte;
          else
            d.rdata = low_fuse_byte;
          d.ctrl[4:0] = 5'h00;
          d.st = ST_IDLE;
        end else if (q.win >= 3'(STORE_WINDOW - 1)) begin
          d.ctrl[4:0] = 5'h00;
          d.st = ST_IDLE;
        end
      end
      ST_PROG: begin
        d.cnt = q.cnt - 23'h1;
        if (q.cnt <= 23'h1) begin
          d.ctrl[4:0] = 5'h00;
          d.halt = 1'b0;
          d.op   = 2'h0;
          d.st   = ST_IDLE;
          if (q.op == 2'h2)
            pend_clr = 1'b1;
        end
      end
      default: d.st = ST_IDLE;
    endcase

    if (pend_clr)
      d.wvalid = '0;

    if (wr_acc && paddr == OFF_PTR)
      d.ptr = pwdata[15:0];
    if (wr_acc && paddr == OFF_DATA)
      d.data = pwdata[15:0];

    d.prdata = 32'h0;
    if (rd_acc) begin
      if (paddr == OFF_CTRL)
        d.prdata = {24'h0, q.ctrl[7], q.busy_rww, 1'b0, q.ctrl[4:0]};
      else if (paddr == OFF_PTR)
        d.prdata = {16'h0, q.ptr};
      else if (paddr == OFF_DATA)
        d.prdata = {16'h0, q.data};
      else if (paddr == OFF_RDATA)
        d.prdata = {24'h0, q.rdata};
      else if (paddr == OFF_STAT)
        d.prdata = {28'h0, q.locks};
      else if (paddr == OFF_EEPROM)
        d.prdata = {31'h0, eeprom_write_busy_bit};
      else if (paddr != OFF_CMD)
        d.pslverr = 1'b1;
    end else if (wr_acc && paddr > OFF_EEPROM)
      d.pslverr = 1'b1;

    d.irq = q.ctrl[BIT_IRQ_EN] && !d.ctrl[BIT_STORE_EN];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q.ctrl     <= CTRL_RESET;
      q.ptr      <= 16'h0000;
      q.data     <= 16'h0000;
      q.rdata    <= 8'h00;
      q.wvalid   <= '0;
      q.prdata   <= 32'h0;
      q.pready   <= 1'b0;
      q.pslverr  <= 1'b0;
      q.irq      <= 1'b0;
      if (q.st == ST_PROG) begin
        q.st  <= d.st;
        q.cnt <= d.cnt;
        q.op  <= d.op;
        q.halt <= d.halt;
        q.busy_rww <= d.busy_rww;
        q.page <= q.page;
        q.locks <= q.locks;
        q.ctrl <= {3'h0, d.ctrl[4:0]};
      end else begin
        q.st    <= ST_IDLE;
        q.cnt   <= 23'h0;
        q.op    <= 2'h0;
        q.halt  <= 1'b0;
        q.busy_rww <= 1'b0;
        q.page  <= '0;
        q.locks <= 4'hF;
      end
    end else begin
      q <= d;
    end
    if (buf_wr)
      buf_mem[buf_idx] <= q.data;
  end

  always_comb begin
    prdata              = q.prdata;
    pready              = q.pready;
    pslverr             = q.pslverr;
    ready_irq           = q.irq;
    region_read_blocked = q.busy_rww;
    cpu_halt            = q.halt;
    flash_prog_busy     = q.st == ST_PROG;
    flash_page_addr     = 7'(q.page);
    flash_prog_op       = q.op;
    loader_lock_bits    = q.locks;
  end
endmodule

// [verification/fsps_properties.sv]
/*
  Port checker for the sequencer, bound to every instance.
  Assumes one clock and the synchronous reset sys_rst.
*/
`timescale 1ns/1ns
module fsps_properties #(
  parameter int         PROG_COUNT      = 20,
  parameter logic [6:0] NO_READ_WHILE_WRITE_REGION_FIRST_PAGE = 7'h70
) (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       eeprom_write_busy_bit,
  input wire logic       cpu_halt,
  input wire logic       region_read_blocked,
  input wire logic       flash_prog_busy,
  input wire logic [6:0] flash_page_addr,
  input wire logic [1:0] flash_prog_op,
  input wire logic [3:0] loader_lock_bits
);
  int busy_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk) busy_cnt <= flash_prog_busy ? busy_cnt + 1 : 0;
  sequence s_page_op;
    $rose(flash_prog_busy) ##0 flash_prog_op inside {2'h1, 2'h2};
  endsequence
  chk_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  chk_busy_bound: assert property (flash_prog_busy |-> busy_cnt <= PROG_COUNT + 2)
    else $error("program op runs too long");
  chk_busy_min: assert property ($fell(flash_prog_busy) |-> busy_cnt >= PROG_COUNT - 1)
    else $error("program op ended early");
  chk_block_start: assert property (s_page_op |-> region_read_blocked)
    else $error("region not blocked at erase or write");
  chk_halt_page: assert property (s_page_op |-> cpu_halt == (flash_page_addr >= NO_READ_WHILE_WRITE_REGION_FIRST_PAGE))
    else $error("halt does not match page region");
  chk_halt_busy: assert property (cpu_halt |-> flash_prog_busy)
    else $error("halt outside program op");
  chk_op_latched: assert property (flash_prog_busy && $past(flash_prog_busy) |-> $stable(flash_page_addr) && $stable(flash_prog_op))
    else $error("page or op changed mid op");
  chk_lock_open: assert property ($rose(region_read_blocked) |-> flash_prog_busy && flash_prog_op != 2'h3)
    else $error("region blocked by lock op");
  chk_ee_block: assert property (eeprom_write_busy_bit [*6] |=> !$rose(flash_prog_busy))
    else $error("op started while eeprom busy");
  chk_lock_mono: assert property ((loader_lock_bits & ~$past(loader_lock_bits)) == 4'h0)
    else $error("loader lock bit unprogrammed");
endmodule
bind fsps_sequencer fsps_properties #(
  .PROG_COUNT(PROG_COUNT), .NO_READ_WHILE_WRITE_REGION_FIRST_PAGE(NO_READ_WHILE_WRITE_REGION_FIRST_PAGE)
) u_props (.clk, .sys_rst, .psel, .penable, .pready, .eeprom_write_busy_bit,
  .cpu_halt, .region_read_blocked, .flash_prog_busy, .flash_page_addr,
  .flash_prog_op, .loader_lock_bits);

// [verification/fsps_core_model.sv]
/*
  Core model: issues stores and loads as APB transfers.
  Assumes the caller enters its tasks right after a rising edge.
*/
`timescale 1ns/1ns
module fsps_core_model (
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // callers may erase and write different pages, load each word once,
  // and re-enable the region before touching it again
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [32:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (!pready && ++n < 16);
    r = {pslverr, prdata};
  endtask
  task automatic idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// [verification/flash_self_program_sequencer_test.sv]
/*
  Bench for the sequencer: the core model drives APB.
  Assumes fuse and memory lock inputs are static.
*/
`timescale 1ns/1ns
module flash_self_program_sequencer_test;
  import fsps_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        eeprom_write_busy_bit = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, ready_irq;
  logic        region_read_blocked, cpu_halt, flash_prog_busy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [32:0] rd;
  logic [6:0]  flash_page_addr;
  logic [1:0]  flash_prog_op;
  logic [3:0]  loader_lock_bits;
  int          fails = 0;
  int          cmp_count = 0;
  always #50 clk = ~clk;
  fsps_sequencer #(.PROG_COUNT(20)) dut (.clk, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .eeprom_write_busy_bit, .low_fuse_byte(8'hE1), .high_fuse_byte(8'h99),
    .memory_lock_bits(2'b10), .ready_irq, .region_read_blocked, .cpu_halt,
    .flash_prog_busy, .flash_page_addr, .flash_prog_op, .loader_lock_bits);
  fsps_core_model core (.clk, .pready, .pslverr, .prdata, .psel, .penable,
    .pwrite, .paddr, .pwdata);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    core.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdreg(input logic [7:0] a);
    core.xfer(1'b0, a, 32'h0, rd);
    core.idle;
  endtask
  task automatic read_lock(input logic [15:0] p, input logic [7:0] m,
                           input logic [7:0] exp);
    wr(OFF_PTR, {16'h0, p});
    wr(OFF_CTRL, 32'h09);
    wr(OFF_CMD, 32'h2);
    core.idle;
    rdreg(OFF_RDATA);
    check(rd[7:0] & m, exp);
    rdreg(OFF_CTRL);
    check(rd[3:0], 4'h0);
  endtask
  task automatic run_op(input logic [7:0] c, input logic [15:0] p,
                        input logic [1:0] op, input logic [6:0] pg);
    int n;
    wr(OFF_PTR, {16'h0, p});
    wr(OFF_DATA, 32'hEB); // lock data: bits 4 and 2 cleared
    wr(OFF_CTRL, {24'h0, c});
    wr(OFF_CMD, 32'h1);
    wr(OFF_PTR, 32'h3F80);
    core.idle;
    @(negedge clk);
    check({flash_prog_busy, flash_prog_op}, {1'b1, op});
    if (op != 2'h3) check(flash_page_addr, pg);
    check(cpu_halt, op != 2'h3 && pg >= 7'h70);
    check(region_read_blocked, op != 2'h3);
    @(posedge clk);
    rdreg(OFF_CTRL);
    check({rd[6], rd[0]}, {op != 2'h3, 1'b1});
    for (n = 0; n < 100 && flash_prog_busy; n++) @(negedge clk);
    check(n inside {[5:20]}, 1'b1);
    check(ready_irq, c[7]);
    @(posedge clk);
    wr(OFF_CTRL, 32'h11);
    wr(OFF_CMD, 32'h1);
    core.idle;
    @(negedge clk);
    check(region_read_blocked, 1'b0);
    @(posedge clk);
  endtask
  task automatic reset_mid_op;
    int n;
    wr(OFF_PTR, 32'h0280);
    wr(OFF_CTRL, 32'h03);
    wr(OFF_CMD, 32'h1);
    core.idle;
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check(flash_prog_busy, 1'b1);
    for (n = 0; n < 100 && flash_prog_busy; n++) @(negedge clk);
    check(region_read_blocked, 1'b1);
    @(posedge clk);
    wr(OFF_CTRL, 32'h01);
    wr(OFF_CMD, 32'h1);
    core.idle;
    @(negedge clk);
    check(region_read_blocked, 1'b0);
    @(posedge clk);
  endtask
  task automatic refused(input logic [7:0] c, input int gap, input logic ee);
    eeprom_write_busy_bit <= ee;
    core.idle;
    wr(OFF_CTRL, {24'h0, c});
    core.idle;
    repeat (gap) @(posedge clk);
    wr(OFF_CMD, 32'h1);
    core.idle;
    @(negedge clk);
    check(flash_prog_busy, 1'b0);
    @(posedge clk);
    eeprom_write_busy_bit <= 1'b0;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdreg(OFF_CTRL);
    check({rd[7:0], loader_lock_bits}, {CTRL_RESET, 4'hF});
    rdreg(8'h40);
    check(rd[32], 1'b1);
    read_lock(PTR_LOCK, 8'h3F, 8'h3E);
    read_lock(PTR_FUSE_LO, 8'hFF, 8'hE1);
    read_lock(PTR_FUSE_HI, 8'hFF, 8'h99);
    run_op(8'h83, 16'h0280, 2'h1, 7'h05);
    run_op(8'h05, 16'h3800, 2'h2, 7'h70);
    run_op(8'h09, PTR_LOCK, 2'h3, 7'h00);
    read_lock(PTR_LOCK, 8'h3F, 8'h2A);
    reset_mid_op;
    refused(8'h07, 0, 1'b0);
    refused(8'h03, 4, 1'b0);
    refused(8'h03, 0, 1'b1);
    tally_and_finish;
  end
endmodule
